// >>> src/bc_message_sequencer.sv
// Bus-controller message sequencer: walks descriptor entries in shared RAM.
// Assumes an external arbiter that answers each memory request with memAck
// and a protocol engine that pulses xferDone after each 1553 message.
//
// How it works
// - Master clear or reset command resets.
// - Reset zeroes config, mask, block status.
// - Tag enable during start/end tag writes.
// - Tag value goes to the second entry word.
// - Undriven tag bus stores all ones.
// - Reset or mode bits give controller mode.
// - Area pointers/counts at 0100/0101, 0104/0105.
// - Control bit 1 makes terminal 31 broadcast.
// - Halt-on-error stops after current message.
// - Masked events give one low interrupt pulse.
// - Start: pointer, begin flag, tag, block, transfer.
// - End: interrupt, pointer, done flag, tag, increments.
// - After halt, no start; pointer on next.
// - Start/reset write-only: bit1 start, bit0 reset.
// - Host wait bounded; host cycle bounded too.
// - Control bus bit: 1 bus A, 0 B.
// - Count reaching all ones ends the frame.
`timescale 1ns/10ps
module bc_message_sequencer (
    input wire logic clk, // 100 MHz system clock
    input wire logic reset_n, // Synchronous reset
    input wire logic master_clear_n, // Synchronous master clear
    input wire logic hostSel, // Host register select
    input wire logic hostWr, // Host write strobe
    input wire logic hostRd, // Host read strobe
    input wire logic [2:0] hostAddr, // Register index
    input wire logic [15:0] hostWrData, // Write data
    output logic [15:0] hostRdData, // Read data, one cycle after hostRd
    output logic memReq, // Shared RAM request
    output logic memWe, // 1 = write cycle
    output logic [15:0] memAddr, // RAM word address
    output logic [15:0] memWrData, // RAM write data
    input wire logic memAck, // Cycle complete, read data valid
    input wire logic [15:0] memRdData, // RAM read data
    output logic time_tag_enable_n, // Time-tag source drive enable
    input wire logic [15:0] tagBus, // Data highway during a tag cycle
    input wire logic tagBusDriven, // Some source drives the highway
    output logic xferStart, // Begin 1553 transfer, one cycle
    output logic xferBusA, // 1 = bus A
    output logic xferBroadcast, // Message is a broadcast
    output logic [15:0] xferBlockAddr, // Message block address
    input wire logic xferDone, // Transfer complete pulse
    input wire logic [7:0] xferErrBits, // Error bits with xferDone
    output logic intr_n, // Low pulse per masked event
    output logic busy, // Sequencer running
    output logic halted, // Stopped on error
    output logic memFault // Memory cycle overran its limit
);
    // Whole module state
    typedef struct packed {
        bc_sequencer_pkg::state_t state;
        logic [15:0] cfg; // Configuration register
        logic [15:0] mask; // Interrupt mask register
        logic [15:0] bsw; // Block status word
        logic [15:0] sp; // Current stack pointer
        logic [15:0] blk; // Message block address
        logic [15:0] ctrl; // Control word
        logic [15:0] cnt; // Incremented message count
        logic [7:0] errBits; // Errors of the last message
        logic [7:0] waitCnt; // Cycles spent on one memory request
        logic memReq;
        logic memWe;
        logic [15:0] memAddr;
        logic [15:0] memWrData;
        logic [15:0] hostRdData;
        logic time_tag_enable_n_n;
        logic intr_n;
        logic xferStart;
        logic xferBusA;
        logic xferBroadcast;
        logic busy;
        logic halted;
        logic memFault;
    } seq_state_t;

    // Everything zero, active-low strobes released
    localparam seq_state_t ST_RESET = '{state: bc_sequencer_pkg::ST_IDLE, time_tag_enable_n_n: 1'b1,
        intr_n: 1'b1, default: '0};

    seq_state_t s_reg; // Registered state
    seq_state_t s_next; // Next state
    logic softRst; // Reset command written
    logic startCmd; // Start command written
    logic areaB; // Area B selected
    logic [15:0] spAddr; // Current-area pointer word
    logic [15:0] cntAddr; // Current-area count word
    logic anyErr; // Last message had an error
    logic [15:0] addBase [4]; // Adder inputs
    logic [7:0] addStep [4];
    logic [15:0] addSum [4]; // Adder outputs

    // Entry and block offsets and pointer steps, all with page wrap
    always_comb begin
        addBase[0] = s_reg.sp;
        addStep[0] = bc_sequencer_pkg::ENTRY_TT_OFS;
        addBase[1] = s_reg.sp;
        addStep[1] = bc_sequencer_pkg::ENTRY_BLK_OFS;
        addBase[2] = s_reg.sp;
        addStep[2] = bc_sequencer_pkg::SP_STEP;
        addBase[3] = s_reg.blk;
        addStep[3] = bc_sequencer_pkg::CMD_OFS;
    end

    // One adder per offset
    for (genvar i = 0; i < 4; i++) begin : gen_add
        pointer_step pointer_step_inst (
            .base(addBase[i]),
            .step(addStep[i]),
            .sum(addSum[i])
        );
    end

    // Command decode and area selection
    always_comb begin
        softRst = hostSel && hostWr && hostAddr == bc_sequencer_pkg::REG_START_IDX
            && hostWrData[bc_sequencer_pkg::RESET_BIT];
        startCmd = hostSel && hostWr && hostAddr == bc_sequencer_pkg::REG_START_IDX
            && hostWrData[bc_sequencer_pkg::START_BIT];
        areaB = s_reg.cfg[bc_sequencer_pkg::CFG_AREA_B_BIT];
        spAddr = areaB ? bc_sequencer_pkg::AREA_B_SP_ADDR
            : bc_sequencer_pkg::AREA_A_SP_ADDR;
        cntAddr = areaB ? bc_sequencer_pkg::AREA_B_CNT_ADDR
            : bc_sequencer_pkg::AREA_A_CNT_ADDR;
        anyErr = |s_reg.errBits;
    end

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.xferStart = 1'b0;
        s_next.intr_n = 1'b1;
        // Host register writes; start/reset stores nothing
        if (hostSel && hostWr) begin
            case (hostAddr)
                bc_sequencer_pkg::REG_MASK_IDX: s_next.mask = hostWrData;
                bc_sequencer_pkg::REG_CFG_IDX: s_next.cfg = hostWrData;
                default: ;
            endcase
        end
        // Host reads; write-only and unused indices read zero
        if (hostSel && hostRd) begin
            case (hostAddr)
                bc_sequencer_pkg::REG_MASK_IDX: s_next.hostRdData = s_reg.mask;
                bc_sequencer_pkg::REG_CFG_IDX: s_next.hostRdData = s_reg.cfg;
                default: s_next.hostRdData = 16'h0000;
            endcase
        end
        // Tag word follows the highway each cycle of the tag write
        if (!s_reg.time_tag_enable_n_n) begin
            s_next.memWrData = tagBusDriven ? tagBus
                : bc_sequencer_pkg::TT_UNDRIVEN;
        end
        // Wait counter for the current memory request
        s_next.waitCnt = (s_reg.memReq && !memAck) ? 8'(s_reg.waitCnt + 8'h01) : 8'h00;
        // Main sequence
        case (s_reg.state)
            bc_sequencer_pkg::ST_IDLE: begin
                // Only controller mode starts; a new start clears a halt
                if (startCmd && s_reg.cfg[bc_sequencer_pkg::CFG_MODE_LSB +: 2]
                        == bc_sequencer_pkg::MODE_BUS_CONTROLLER) begin
                    s_next.state = bc_sequencer_pkg::ST_RD_SP;
                    s_next.busy = 1'b1;
                    s_next.halted = 1'b0;
                    s_next.memFault = 1'b0;
                end
            end
            bc_sequencer_pkg::ST_RD_SP: begin
                if (memAck) begin
                    s_next.sp = memRdData;
                    s_next.state = bc_sequencer_pkg::ST_WR_BEGIN;
                end
            end
            bc_sequencer_pkg::ST_WR_BEGIN: begin
                if (memAck) s_next.state = bc_sequencer_pkg::ST_WR_TT1;
            end
            bc_sequencer_pkg::ST_WR_TT1: begin
                if (memAck) s_next.state = bc_sequencer_pkg::ST_RD_BLK;
            end
            bc_sequencer_pkg::ST_RD_BLK: begin
                if (memAck) begin
                    s_next.blk = memRdData;
                    s_next.state = bc_sequencer_pkg::ST_RD_CW;
                end
            end
            bc_sequencer_pkg::ST_RD_CW: begin
                if (memAck) begin
                    s_next.ctrl = memRdData;
                    s_next.state = bc_sequencer_pkg::ST_RD_CMD;
                end
            end
            bc_sequencer_pkg::ST_RD_CMD: begin
                // Command word gives the terminal address
                if (memAck) begin
                    s_next.xferStart = 1'b1;
                    s_next.xferBusA = s_reg.ctrl[bc_sequencer_pkg::CW_BUS_A_BIT];
                    s_next.xferBroadcast = s_reg.ctrl[bc_sequencer_pkg::CW_RT31_BCAST_BIT]
                        && memRdData[15:11] == bc_sequencer_pkg::RT_BROADCAST;
                    s_next.state = bc_sequencer_pkg::ST_XFER;
                end
            end
            bc_sequencer_pkg::ST_XFER: begin
                // Interrupt comes first in the end sequence
                if (xferDone) begin
                    s_next.errBits = xferErrBits;
                    if (|xferErrBits ? s_reg.mask[bc_sequencer_pkg::MSK_ERR_BIT]
                            : s_reg.mask[bc_sequencer_pkg::MSK_DONE_BIT]) begin
                        s_next.intr_n = 1'b0;
                    end
                    s_next.state = bc_sequencer_pkg::ST_RD_SP2;
                end
            end
            bc_sequencer_pkg::ST_RD_SP2: begin
                if (memAck) begin
                    s_next.sp = memRdData;
                    s_next.state = bc_sequencer_pkg::ST_WR_END;
                end
            end
            bc_sequencer_pkg::ST_WR_END: begin
                if (memAck) s_next.state = bc_sequencer_pkg::ST_WR_TT2;
            end
            bc_sequencer_pkg::ST_WR_TT2: begin
                if (memAck) s_next.state = bc_sequencer_pkg::ST_WR_SP;
            end
            bc_sequencer_pkg::ST_WR_SP: begin
                if (memAck) s_next.state = bc_sequencer_pkg::ST_RD_CNT;
            end
            bc_sequencer_pkg::ST_RD_CNT: begin
                if (memAck) begin
                    s_next.cnt = 16'(memRdData + 16'h0001);
                    s_next.state = bc_sequencer_pkg::ST_WR_CNT;
                end
            end
            bc_sequencer_pkg::ST_WR_CNT: begin
                if (memAck) begin
                    if (s_reg.cnt == bc_sequencer_pkg::COUNT_DONE) begin
                        // Whole frame sent
                        s_next.state = bc_sequencer_pkg::ST_IDLE;
                        s_next.busy = 1'b0;
                        s_next.intr_n = !s_reg.mask[bc_sequencer_pkg::MSK_FRAME_BIT];
                    end else if (anyErr && s_reg.cfg[bc_sequencer_pkg::CFG_HALT_BIT]) begin
                        // Pointer already stepped past the failed entry
                        s_next.state = bc_sequencer_pkg::ST_IDLE;
                        s_next.busy = 1'b0;
                        s_next.halted = 1'b1;
                    end else begin
                        s_next.state = bc_sequencer_pkg::ST_RD_SP;
                    end
                end
            end
            default: s_next.state = bc_sequencer_pkg::ST_IDLE;
        endcase
        // A stuck request would hold the host past its wait limit
        if (s_reg.memReq && !memAck
                && s_reg.waitCnt == 8'(bc_sequencer_pkg::MEM_WAIT_CYCLES - 8'h01)) begin
            s_next.state = bc_sequencer_pkg::ST_IDLE;
            s_next.busy = 1'b0;
            s_next.memFault = 1'b1;
            s_next.waitCnt = 8'h00; // Dropped request starts no further count
        end
        // Set up the memory cycle of a newly entered state
        if (s_next.state != s_reg.state) begin
            s_next.memReq = 1'b1;
            s_next.memWe = 1'b0;
            s_next.time_tag_enable_n_n = 1'b1;
            case (s_next.state)
                bc_sequencer_pkg::ST_RD_SP: s_next.memAddr = spAddr;
                bc_sequencer_pkg::ST_RD_SP2: s_next.memAddr = spAddr;
                bc_sequencer_pkg::ST_WR_BEGIN: begin
                    s_next.bsw = 16'h0000;
                    s_next.bsw[bc_sequencer_pkg::BSW_BEGIN_BIT] = 1'b1;
                    s_next.memWe = 1'b1;
                    s_next.memAddr = s_next.sp;
                    s_next.memWrData = s_next.bsw;
                end
                bc_sequencer_pkg::ST_WR_END: begin
                    s_next.bsw = {8'h00, s_reg.errBits};
                    s_next.bsw[bc_sequencer_pkg::BSW_DONE_BIT] = 1'b1;
                    s_next.bsw[bc_sequencer_pkg::BSW_ERR_BIT] = anyErr;
                    s_next.memWe = 1'b1;
                    s_next.memAddr = s_next.sp;
                    s_next.memWrData = s_next.bsw;
                end
                bc_sequencer_pkg::ST_WR_TT1, bc_sequencer_pkg::ST_WR_TT2: begin
                    s_next.time_tag_enable_n_n = 1'b0;
                    s_next.memWe = 1'b1;
                    s_next.memAddr = addSum[0];
                    s_next.memWrData = tagBusDriven ? tagBus : bc_sequencer_pkg::TT_UNDRIVEN;
                end
                bc_sequencer_pkg::ST_RD_BLK: s_next.memAddr = addSum[1];
                bc_sequencer_pkg::ST_RD_CW: s_next.memAddr = s_next.blk;
                bc_sequencer_pkg::ST_RD_CMD: s_next.memAddr = addSum[3];
                bc_sequencer_pkg::ST_WR_SP: begin
                    s_next.memWe = 1'b1;
                    s_next.memAddr = spAddr;
                    s_next.memWrData = addSum[2];
                end
                bc_sequencer_pkg::ST_RD_CNT: s_next.memAddr = cntAddr;
                bc_sequencer_pkg::ST_WR_CNT: begin
                    s_next.memWe = 1'b1;
                    s_next.memAddr = cntAddr;
                    s_next.memWrData = s_next.cnt;
                end
                default: s_next.memReq = 1'b0; // Idle and transfer hold the RAM free
            endcase
        end
        // Either reset source restores power-on state, aborting any transfer
        if (!master_clear_n || softRst) s_next = ST_RESET;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) s_reg <= ST_RESET;
        else s_reg <= s_next;
    end

    // Outputs straight from the state register
    assign hostRdData = s_reg.hostRdData;
    assign memReq = s_reg.memReq;
    assign memWe = s_reg.memWe;
    assign memAddr = s_reg.memAddr;
    assign memWrData = s_reg.memWrData;
    assign time_tag_enable_n = s_reg.time_tag_enable_n_n;
    assign xferStart = s_reg.xferStart;
    assign xferBusA = s_reg.xferBusA;
    assign xferBroadcast = s_reg.xferBroadcast;
    assign xferBlockAddr = s_reg.blk;
    assign intr_n = s_reg.intr_n;
    assign busy = s_reg.busy;
    assign halted = s_reg.halted;
    assign memFault = s_reg.memFault;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    reset_clears_a: assert property (!master_clear_n |=> s_reg.cfg == 16'h0000
        && s_reg.mask == 16'h0000 && s_reg.bsw == 16'h0000)
        else $error("Reset left a register set");
    soft_reset_a: assert property (softRst |=> s_reg.state == bc_sequencer_pkg::ST_IDLE
        && !memReq && s_reg.cfg == 16'h0000)
        else $error("Reset command did not abort");
    tag_enable_only_a: assert property (!time_tag_enable_n |-> memWe && memReq
        && s_reg.state inside {bc_sequencer_pkg::ST_WR_TT1, bc_sequencer_pkg::ST_WR_TT2})
        else $error("Tag enable outside tag write");
    tag_floating_a: assert property (!time_tag_enable_n && !tagBusDriven
        && master_clear_n && !softRst |=> time_tag_enable_n || memWrData == 16'hFFFF)
        else $error("Floating tag not stored as ones");
    area_a_pointer_a: assert property (s_reg.state == bc_sequencer_pkg::ST_RD_SP
        && memReq && !areaB |-> memAddr == 16'h0100)
        else $error("Wrong area A pointer word");
    pointer_step_a: assert property (s_reg.state == bc_sequencer_pkg::ST_WR_SP
        && memReq |-> memWrData == {s_reg.sp[15:8], 8'(s_reg.sp[7:0] + 8'h04)})
        else $error("Stack pointer not stepped by four");
    frame_done_a: assert property (s_reg.state == bc_sequencer_pkg::ST_WR_CNT && memAck
        && s_reg.cnt == 16'hFFFF && master_clear_n && !softRst
        |=> s_reg.state == bc_sequencer_pkg::ST_IDLE && !busy ##1 !xferStart [*2])
        else $error("Frame did not end at all ones");
    halt_error_a: assert property (s_reg.state == bc_sequencer_pkg::ST_WR_CNT && memAck
        && s_reg.cnt != 16'hFFFF && anyErr && s_reg.cfg[0] && master_clear_n && !softRst
        |=> halted && s_reg.state == bc_sequencer_pkg::ST_IDLE)
        else $error("No halt on error");
    start_order_a: assert property (xferStart |-> $past(s_reg.state) ==
        bc_sequencer_pkg::ST_RD_CMD && xferBusA == s_reg.ctrl[7])
        else $error("Transfer started out of order");
    intr_pulse_a: assert property (!intr_n |=> intr_n)
        else $error("Interrupt pulse longer than one cycle");
    mem_wait_a: assert property (s_reg.waitCnt < bc_sequencer_pkg::MEM_WAIT_CYCLES)
        else $error("Memory request overran limit");

    frame_done_c: cover property (s_reg.state == bc_sequencer_pkg::ST_WR_CNT && memAck
        && s_reg.cnt == 16'hFFFF);
    halt_c: cover property (!halted ##1 halted);
    next_entry_c: cover property (s_reg.state == bc_sequencer_pkg::ST_WR_CNT
        ##1 s_reg.state == bc_sequencer_pkg::ST_RD_SP);

endmodule : bc_message_sequencer

// >>> src/bc_sequencer_pkg.sv
// Constants and types for the bus-controller message sequencer.
// Assumes a 16-bit shared RAM space and a 3-bit host register index.
package bc_sequencer_pkg;

    // Fixed shared-RAM words of the two map areas
    localparam logic [15:0] AREA_A_SP_ADDR = 16'h0100; // Stack pointer, area A
    localparam logic [15:0] AREA_A_CNT_ADDR = 16'h0101; // Message count, area A
    localparam logic [15:0] AREA_B_SP_ADDR = 16'h0104; // Stack pointer, area B
    localparam logic [15:0] AREA_B_CNT_ADDR = 16'h0105; // Message count, area B

    // Host register indices
    localparam logic [2:0] REG_MASK_IDX = 3'h0; // Interrupt mask, read/write
    localparam logic [2:0] REG_CFG_IDX = 3'h1; // Configuration, read/write
    localparam logic [2:0] REG_START_IDX = 3'h3; // Start/reset, write-only

    // Start/reset register bits
    localparam int START_BIT = 1;
    localparam int RESET_BIT = 0;

    // Configuration register fields
    localparam int CFG_HALT_BIT = 0; // Stop on error
    localparam int CFG_AREA_B_BIT = 1; // Current area: 1 = B
    localparam int CFG_MODE_LSB = 2; // Two-bit mode field
    localparam logic [1:0] MODE_BUS_CONTROLLER = 2'h0; // Value after reset

    // Interrupt mask bits
    localparam int MSK_DONE_BIT = 0;
    localparam int MSK_ERR_BIT = 1;
    localparam int MSK_FRAME_BIT = 2;

    // Block status word layout
    localparam int BSW_BEGIN_BIT = 15; // Message in progress
    localparam int BSW_DONE_BIT = 14; // Message done
    localparam int BSW_ERR_BIT = 12; // Any error

    // Descriptor entry and message block offsets
    localparam logic [7:0] ENTRY_TT_OFS = 8'h01; // Time-tag word
    localparam logic [7:0] ENTRY_BLK_OFS = 8'h03; // Message block address word
    localparam logic [7:0] SP_STEP = 8'h04; // One entry is four words
    localparam logic [7:0] CMD_OFS = 8'h01; // Command word follows control word

    // Control word fields
    localparam int CW_BUS_A_BIT = 7; // 1 = bus A, 0 = bus B
    localparam int CW_RT31_BCAST_BIT = 1; // Terminal 31 is broadcast
    localparam logic [4:0] RT_BROADCAST = 5'h1F;

    // Values
    localparam logic [15:0] COUNT_DONE = 16'hFFFF; // Frame finished
    localparam logic [15:0] TT_UNDRIVEN = 16'hFFFF; // Floating data highway

    // Longest internal memory cycle seen by a waiting host
    localparam int CLK_PERIOD_NS = 10;
    localparam int MEM_WAIT_MAX_NS = 1800;
    localparam logic [7:0] MEM_WAIT_CYCLES = 8'(MEM_WAIT_MAX_NS / CLK_PERIOD_NS);

    // Sequencer states, Gray coded along the message path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD_SP = 4'h1,
        ST_WR_BEGIN = 4'h3,
        ST_WR_TT1 = 4'h2,
        ST_RD_BLK = 4'h6,
        ST_RD_CW = 4'h7,
        ST_RD_CMD = 4'h5,
        ST_XFER = 4'h4,
        ST_RD_SP2 = 4'hC,
        ST_WR_END = 4'hD,
        ST_WR_TT2 = 4'hF,
        ST_WR_SP = 4'hE,
        ST_RD_CNT = 4'hA,
        ST_WR_CNT = 4'hB
    } state_t;

endpackage : bc_sequencer_pkg

// >>> src/pointer_step.sv
// Pointer adder that keeps the high byte and wraps the low byte.
// Assumes pointers never leave their 256-word page.
`timescale 1ns/10ps
module pointer_step (
    input wire logic [15:0] base, // Pointer value
    input wire logic [7:0] step, // Amount to add
    output logic [15:0] sum // High byte kept, low byte wrapped
);
    // High byte is a plain register in the pointer, low byte a counter
    always_comb begin
        sum = {base[15:8], 8'(base[7:0] + step)};
    end
endmodule : pointer_step

// >>> tb/bc_partner.sv
// Shared RAM with arbiter, 1553 engine and time-tag source.
// Assumes one clock; the RAM answers each request after two waits.
`timescale 1ns/10ps
module bc_partner (
    input wire logic clk,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWrData,
    output logic memAck,
    output logic [15:0] memRdData,
    input wire logic time_tag_enable_n,
    output logic [15:0] tagBus,
    output logic tagBusDriven,
    input wire logic xferStart,
    output logic xferDone,
    output logic [7:0] xferErrBits,
    input wire logic tagOn,
    input wire logic [7:0] errSet
);
    logic [15:0] mem [0:511]; // Low 512 words of the RAM
    logic [1:0] wt = 2'h0; // Wait states so far
    logic [3:0] xc = 4'h0; // Transfer length counter
    initial memAck = 1'b0;
    initial memRdData = 16'h0;
    initial xferDone = 1'b0;
    initial xferErrBits = 8'h0;
    // Source drives only while enabled; a floating highway reads high
    assign tagBusDriven = tagOn && !time_tag_enable_n;
    assign tagBus = tagBusDriven ? 16'h1234 : 16'hFFFF;
    // Host side always ends its cycle quickly, idle data toggles
    always @(posedge clk) begin
        memAck <= 1'b0;
        memRdData <= ~memRdData;
        if (memReq && !memAck) begin
            wt <= wt + 2'h1;
            if (wt == 2'h1) begin
                memAck <= 1'b1;
                wt <= 2'h0;
                if (memWe) mem[memAddr[8:0]] <= memWrData;
                else memRdData <= mem[memAddr[8:0]];
            end
        end
    end
    // Done seven cycles after start; error bits only valid with done
    always @(posedge clk) begin
        xferDone <= (xc == 4'h6);
        xferErrBits <= (xc == 4'h6) ? errSet : ~xferErrBits;
        xc <= xferStart ? 4'h1 : ((xc != 4'h0) ? xc + 4'h1 : 4'h0);
    end
endmodule : bc_partner

// >>> tb/bus_controller_message_sequencer_test.sv
// Bench for the message sequencer: frames, halt on error, resets.
// Assumes bc_partner stands in for the host RAM and the 1553 engine.
`timescale 1ns/10ps
module bus_controller_message_sequencer_test;
    logic clk = 0, reset_n = 0, master_clear_n = 1, hostSel = 0, hostWr = 0, hostRd = 0;
    logic [2:0] hostAddr = 3'h0;
    logic [15:0] hostWrData = 16'h0, hostRdData, memAddr, memWrData, memRdData, tagBus, blk, r;
    logic memReq, memWe, memAck, time_tag_enable_n, tagBusDriven, xferStart, xferBusA;
    logic xferBroadcast, xferDone, intr_n, busy, halted, memFault, tagOn = 1;
    logic [7:0] xferErrBits, errSet = 8'h0;
    logic [1:0] seen [0:3]; // Bus and broadcast per started message
    int errTotal = 0, cmpCount = 0, ip = 0, xi = 0;
    always #5 clk = ~clk;
    bc_message_sequencer bc_message_sequencer_inst (.*, .xferBlockAddr(blk));
    bc_partner bc_partner_inst (.*);
    // Count interrupt pulses and log each transfer start
    always @(posedge clk) begin
        if (intr_n === 1'b0) ip++;
        if (xferStart === 1'b1) seen[xi++] = {xferBusA, xferBroadcast};
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        cmpCount++;
        if (g !== e) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic hw(input logic [2:0] a, input logic [15:0] d);
        @(negedge clk) {hostSel, hostWr, hostAddr, hostWrData} = {2'b11, a, d};
        @(negedge clk) {hostSel, hostWr} = 2'b00;
    endtask : hw
    task automatic hr(input logic [2:0] a);
        @(negedge clk) {hostSel, hostRd, hostAddr} = {2'b11, a};
        @(negedge clk) {hostSel, hostRd} = 2'b00;
        r = hostRdData;
    endtask : hr
    // Host preload: pointer, ones-complement count, blocks, control words
    task automatic setup(input logic [15:0] c2);
        bc_partner_inst.mem['h100] = 16'h0000;
        bc_partner_inst.mem['h101] = 16'hFFFD;
        bc_partner_inst.mem[3] = 16'h0140;
        bc_partner_inst.mem[7] = 16'h0180;
        bc_partner_inst.mem['h140] = 16'h0080;
        bc_partner_inst.mem['h141] = 16'h0C21;
        bc_partner_inst.mem['h180] = c2;
        bc_partner_inst.mem['h181] = 16'hF823;
        hw(3'h3, 16'h0002);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        chk("idle", 16'h0, 16'(busy));
    endtask : setup
    task automatic t_frame;
        hw(3'h0, 16'h0007);
        setup(16'h0002);
        chk("sp", 16'h0008, bc_partner_inst.mem['h100]);
        chk("count", 16'hFFFF, bc_partner_inst.mem['h101]);
        chk("tag", 16'h1234, bc_partner_inst.mem[5]);
        chk("bsw", 16'h4000, bc_partner_inst.mem[0]);
        chk("busA", 2'b10, seen[0]);
        chk("bcast", 2'b01, seen[1]);
        chk("intr", 16'h3, 16'(ip));
        chk("msgs", 16'h2, 16'(xi));
        chk("blkAddr", 16'h0180, blk);
        chk("fault", 16'h0, 16'(memFault));
    endtask : t_frame
    task automatic t_halt;
        {tagOn, errSet} = 9'h001;
        hw(3'h1, 16'h0001);
        setup(16'h0000);
        chk("tagFF", 16'hFFFF, bc_partner_inst.mem[1]);
        chk("bswErr", 16'h5001, bc_partner_inst.mem[0]);
        chk("spHalt", 16'h0004, bc_partner_inst.mem['h100]);
        chk("halted", 1'b1, halted);
        chk("msgs", 16'h3, 16'(xi));
    endtask : t_halt
    task automatic t_reset;
        hw(3'h3, 16'h0002);
        hw(3'h3, 16'h0001);
        chk("busy", 1'b0, busy);
        for (int a = 0; a < 4; a++) begin
            hr(3'(a));
            chk("reg", 16'h0, r);
        end
        hw(3'h1, 16'h0005);
        hw(3'h3, 16'h0002);
        chk("modeStart", 16'h0, 16'(busy));
        @(negedge clk) master_clear_n = 0;
        @(negedge clk) master_clear_n = 1;
        hr(3'h1);
        chk("clear", 16'h0, r);
    endtask : t_reset
    // One message from area B; area A pointer word must stay untouched
    task automatic t_area;
        bc_partner_inst.mem['h104] = 16'h0010;
        bc_partner_inst.mem['h105] = 16'hFFFE;
        bc_partner_inst.mem['h13] = 16'h0140;
        hw(3'h1, 16'h0002);
        hw(3'h3, 16'h0002);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        chk("spB", 16'h0014, bc_partner_inst.mem['h104]);
        chk("countB", 16'hFFFF, bc_partner_inst.mem['h105]);
        chk("spA", 16'h0004, bc_partner_inst.mem['h100]);
    endtask : t_area
    task automatic wrapUp;
        $display("errors %0d compares %0d", errTotal, cmpCount);
        if (errTotal == 0 && cmpCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrapUp
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1;
        t_frame();
        t_halt();
        t_reset();
        t_area();
        wrapUp();
    end
    // Watchdog well beyond three short frames
    initial begin
        #200us;
        errTotal++;
        wrapUp();
    end
endmodule : bus_controller_message_sequencer_test
